// ---- gpab_consts.svh ----
// Constants for the two-port GPIO block: register byte offsets, reset values.
// Assumes inclusion by bare name from the package and the design file.
`ifndef GPAB_CONSTS_SVH
`define GPAB_CONSTS_SVH
`define GPAB_OFF_PA_DATA 8'h00
`define GPAB_OFF_PA_DIR 8'h04
`define GPAB_OFF_PA_LED 8'h08
`define GPAB_OFF_PB_DATA 8'h0c
`define GPAB_OFF_PB_DIR 8'h10
`define GPAB_DIR_RST 8'h00
`define GPAB_LED_RST 8'h00
`define GPAB_ADC_SEL_W 5
`define GPAB_ELS_OFF 2'h0
`endif

// ---- gpab_pkg.sv ----
// Types shared by the two-port GPIO block.
// Assumes gpab_consts.svh is on the include path.
`include "gpab_consts.svh"
package gpab_pkg;
  // Per-pin drive bundle: output level, output enable
  typedef struct packed {
    logic [7:0] out;
    logic [7:0] oe;
  } gpab_pins_t;
  // Peripheral claims over port B
  typedef struct packed {
    logic i2c_module_enable;
    logic sda_low;
    logic scl_low;
    logic serial_iface_enable;
    logic txd_level;
    logic [3:0] tim_out;
    logic [3:0] tim_oe;
  } gpab_periph_t;
endpackage

// ---- gpab_top.sv ----
// Two 8-bit GPIO ports with a classic Wishbone register slave.
// Assumes pins come from outside the clock domain; peripheral controls are synchronous.
//
// Decided for this implementation: register access over Wishbone.
`timescale 1ns/1ps
`include "gpab_consts.svh"
module gpab_top #(
  // Pins per port; the open-drain split of port B assumes eight
  parameter int PORT_W = 8,
  // Port A pins that the analog channel select can claim
  parameter int ANALOG_PINS = 8
) (
  // Clock, reset, enable
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Port A pins
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  output logic [7:0] pa_led_drive,
  output logic [7:0] pa_analog_en,
  // Port B pins
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  // ADC channel select and peripheral controls
  input wire logic [4:0] analog_channel_select,
  input wire gpab_pkg::gpab_periph_t periph,
  input wire logic [7:0] timer_edge_level_select,
  // Synchronised pin levels delivered to peripherals
  output logic [7:0] pb_level
);
  // Register map, one byte each in the low lane of a 32-bit word:
  //   0x00 port A data, 0x04 port A direction, 0x08 port A LED drive,
  //   0x0c port B data, 0x10 port B direction; anything else reads zero.
  // Storage for the five registers
  logic [7:0] port_a_data_latch_r;
  logic [7:0] port_a_direction_r;
  logic [7:0] port_a_led_drive_enable_r;
  logic [7:0] port_b_data_latch_r;
  logic [7:0] port_b_direction_r;
  logic [7:0] pa_s1_r, pa_s2_r, pb_s1_r, pb_s2_r;
  logic [31:0] rdat_nxt;
  logic wr_go, rd_go;
  logic [7:0] a_analog;
  logic [3:0] tim_own;
  gpab_pkg::gpab_pins_t pb_drv;

  // Refuse sizes the pin logic cannot serve
  if (PORT_W != 8) begin : g_bad_width
    $error("gpab_top is written for eight-pin ports");
  end
  if (ANALOG_PINS < 1 || ANALOG_PINS > PORT_W ||
      ANALOG_PINS > (1 << `GPAB_ADC_SEL_W)) begin : g_bad_analog
    $error("analog pin count out of range");
  end

  assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_sel_i[0] && !wb_ack_o && clk_en;
  assign rd_go = wb_cyc_i && wb_stb_i && !wb_ack_o && clk_en;

  // Two-flop synchronisers; first stage feeds only the second
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      pa_s1_r <= 8'h00;
      pa_s2_r <= 8'h00;
      pb_s1_r <= 8'h00;
      pb_s2_r <= 8'h00;
    end else if (clk_en) begin
      pa_s1_r <= pa_in;
      pa_s2_r <= pa_s1_r;
      pb_s1_r <= pb_in;
      pb_s2_r <= pb_s1_r;
    end
  end
  assign pb_level = pb_s2_r;

  // Data latches have no reset so software contents survive reset
  always_ff @(posedge sys_clk) begin
    if (wr_go && wb_adr_i == `GPAB_OFF_PA_DATA) begin
      port_a_data_latch_r <= wb_dat_i[7:0];
    end
    if (wr_go && wb_adr_i == `GPAB_OFF_PB_DATA) begin
      port_b_data_latch_r <= wb_dat_i[7:0];
    end
  end

  // Direction and LED control registers
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      port_a_direction_r <= `GPAB_DIR_RST;
      port_b_direction_r <= `GPAB_DIR_RST;
      port_a_led_drive_enable_r <= `GPAB_LED_RST;
    end else if (wr_go) begin
      case (wb_adr_i)
        `GPAB_OFF_PA_DIR: port_a_direction_r <= wb_dat_i[7:0];
        `GPAB_OFF_PB_DIR: port_b_direction_r <= wb_dat_i[7:0];
        `GPAB_OFF_PA_LED: port_a_led_drive_enable_r <= wb_dat_i[7:0];
        default: ;
      endcase
    end
  end

  // Read mux: output pins show the latch, inputs the synchronised pin
  always_comb begin
    rdat_nxt = 32'h0000_0000;
    case (wb_adr_i)
      `GPAB_OFF_PA_DATA: rdat_nxt[7:0] = (port_a_data_latch_r & port_a_direction_r)
        | (pa_s2_r & ~port_a_direction_r);
      `GPAB_OFF_PB_DATA: rdat_nxt[7:0] = (port_b_data_latch_r & port_b_direction_r)
        | (pb_s2_r & ~port_b_direction_r);
      `GPAB_OFF_PA_DIR: rdat_nxt[7:0] = port_a_direction_r;
      `GPAB_OFF_PB_DIR: rdat_nxt[7:0] = port_b_direction_r;
      `GPAB_OFF_PA_LED: rdat_nxt[7:0] = port_a_led_drive_enable_r;
      default: rdat_nxt = 32'h0000_0000; // Unmapped reads as zero, still acked
    endcase
  end

  // One-wait-state ack; dropped at the next clock-enabled edge after it is given
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else if (clk_en) begin
      wb_ack_o <= rd_go;
      if (rd_go) begin
        wb_dat_o <= rdat_nxt;
      end
    end
  end

  // Analog channel decode; selects at or above ANALOG_PINS claim no port A pin
  always_comb begin
    a_analog = 8'h00;
    // Codes past the last analog pin address channels inside the converter
    if (analog_channel_select < 5'(ANALOG_PINS)) begin
      a_analog[analog_channel_select[2:0]] = 1'b1;
    end
  end
  assign pa_analog_en = a_analog;
  assign pa_out = port_a_data_latch_r;
  assign pa_oe = port_a_direction_r & ~a_analog;
  // LED drive only meaningful on digital outputs
  assign pa_led_drive = port_a_led_drive_enable_r & port_a_direction_r & ~a_analog;

  // Timer owns pin when its edge/level select pair is non-zero
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_tim
      assign tim_own[gi] = timer_edge_level_select[2*gi+1 -: 2] != `GPAB_ELS_OFF;
    end
  endgenerate

  // Port B drive mux; peripherals override, stored registers reapply on release
  always_comb begin
    pb_drv.out = 8'h00;
    pb_drv.oe = 8'h00;
    // Pins 0..3 open drain: enable only when pulling low
    for (int i = 0; i < 4; i++) begin
      pb_drv.oe[i] = port_b_direction_r[i] & ~port_b_data_latch_r[i];
    end
    if (periph.i2c_module_enable) begin
      pb_drv.oe[0] = periph.sda_low;
      pb_drv.oe[1] = periph.scl_low;
    end
    if (periph.serial_iface_enable) begin
      pb_drv.oe[2] = ~periph.txd_level;
      pb_drv.oe[3] = 1'b0; // Receive pin is input only
    end
    for (int i = 4; i < 8; i++) begin
      pb_drv.out[i] = tim_own[i-4] ? periph.tim_out[i-4] : port_b_data_latch_r[i];
      pb_drv.oe[i] = tim_own[i-4] ? periph.tim_oe[i-4] : port_b_direction_r[i];
    end
  end
  assign pb_out = pb_drv.out;
  assign pb_oe = pb_drv.oe;

  // Checks
  property p_dir_reset;
    @(posedge sys_clk) !nrst |=> (port_a_direction_r == 8'h00 && port_b_direction_r == 8'h00);
  endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");
  property p_od_low;
    @(posedge sys_clk) disable iff (!nrst) pb_oe[0] |-> pb_out[0] == 1'b0;
  endproperty
  a_od_low: assert property (p_od_low) else $error("open drain drove high");
  property p_analog_off;
    @(posedge sys_clk) disable iff (!nrst)
      analog_channel_select < 5'd8 |-> pa_oe[analog_channel_select[2:0]] == 1'b0;
  endproperty
  a_analog_off: assert property (p_analog_off) else $error("analog pin driven");
  property p_pa_oe;
    @(posedge sys_clk) disable iff (!nrst) analog_channel_select >= 5'd8 |-> pa_oe == port_a_direction_r;
  endproperty
  a_pa_oe: assert property (p_pa_oe) else $error("port A oe wrong");
  property p_dir_wr;
    @(posedge sys_clk) disable iff (!nrst)
      wr_go && wb_adr_i == `GPAB_OFF_PB_DIR |=> port_b_direction_r == $past(wb_dat_i[7:0]);
  endproperty
  a_dir_wr: assert property (p_dir_wr) else $error("port B direction write lost");
  property p_lat_wr;
    @(posedge sys_clk) disable iff (!nrst)
      wr_go && wb_adr_i == `GPAB_OFF_PA_DATA |=> port_a_data_latch_r == $past(wb_dat_i[7:0]);
  endproperty
  a_lat_wr: assert property (p_lat_wr) else $error("port A latch write lost");
  property p_rd_pa;
    @(posedge sys_clk) disable iff (!nrst)
      rd_go && wb_adr_i == `GPAB_OFF_PA_DATA |=>
      wb_dat_o[7:0] == (($past(port_a_data_latch_r) & $past(port_a_direction_r))
        | ($past(pa_s2_r) & ~$past(port_a_direction_r)));
  endproperty
  a_rd_pa: assert property (p_rd_pa) else $error("port A read wrong");
  property p_rd_pb;
    @(posedge sys_clk) disable iff (!nrst)
      rd_go && wb_adr_i == `GPAB_OFF_PB_DATA && port_b_direction_r == 8'h00 |=>
      wb_dat_o[7:0] == $past(pb_s2_r);
  endproperty
  a_rd_pb: assert property (p_rd_pb) else $error("port B read wrong");
  property p_i2c;
    @(posedge sys_clk) disable iff (!nrst) periph.i2c_module_enable |-> pb_oe[1] == periph.scl_low;
  endproperty
  a_i2c: assert property (p_i2c) else $error("I2C clock not routed");
  property p_led;
    @(posedge sys_clk) disable iff (!nrst) pa_led_drive[0] |-> port_a_direction_r[0];
  endproperty
  a_led: assert property (p_led) else $error("LED drive on input");
  property p_ack_pulse;
    @(posedge sys_clk) disable iff (!nrst) wb_ack_o && clk_en |=> !wb_ack_o;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack held two cycles");

  // Register writes land at the edge that takes them
  property p_dir_a_wr;
    @(posedge sys_clk) disable iff (!nrst)
      wr_go && wb_adr_i == `GPAB_OFF_PA_DIR |=> port_a_direction_r == $past(wb_dat_i[7:0]);
  endproperty
  a_dir_a_wr: assert property (p_dir_a_wr) else $error("port A direction write lost");

  property p_led_wr;
    @(posedge sys_clk) disable iff (!nrst)
      wr_go && wb_adr_i == `GPAB_OFF_PA_LED |=>
      port_a_led_drive_enable_r == $past(wb_dat_i[7:0]);
  endproperty
  a_led_wr: assert property (p_led_wr) else $error("LED enable write lost");

  property p_pb_lat_wr;
    @(posedge sys_clk) disable iff (!nrst)
      wr_go && wb_adr_i == `GPAB_OFF_PB_DATA |=>
      port_b_data_latch_r == $past(wb_dat_i[7:0]);
  endproperty
  a_pb_lat_wr: assert property (p_pb_lat_wr) else $error("port B latch write lost");

  // Read data and handshake
  property p_rd_pb_all;
    @(posedge sys_clk) disable iff (!nrst)
      rd_go && wb_adr_i == `GPAB_OFF_PB_DATA |=>
      wb_dat_o[7:0] == (($past(port_b_data_latch_r) & $past(port_b_direction_r))
        | ($past(pb_s2_r) & ~$past(port_b_direction_r)));
  endproperty
  a_rd_pb_all: assert property (p_rd_pb_all) else $error("port B mixed read wrong");

  property p_dat_hi;
    @(posedge sys_clk) disable iff (!nrst) wb_ack_o |-> wb_dat_o[31:8] == 24'h000000;
  endproperty
  a_dat_hi: assert property (p_dat_hi) else $error("upper read lanes not zero");

  property p_ack_follow;
    @(posedge sys_clk) disable iff (!nrst) rd_go |=> wb_ack_o;
  endproperty
  a_ack_follow: assert property (p_ack_follow) else $error("request not acked");

  // A low enable must freeze state, or a stalled bus would see registers move
  property p_freeze;
    @(posedge sys_clk) disable iff (!nrst)
      !clk_en |=> $stable(port_a_direction_r) && $stable(port_b_direction_r) && $stable(wb_ack_o);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while frozen");

  // Port B routing: open drain low half, peripherals override the port
  property p_pb_oe_hi;
    @(posedge sys_clk) disable iff (!nrst) tim_own == 4'h0 |-> pb_oe[7:4] == port_b_direction_r[7:4];
  endproperty
  a_pb_oe_hi: assert property (p_pb_oe_hi) else $error("port B high enables wrong");

  property p_od_gpio;
    @(posedge sys_clk) disable iff (!nrst)
      !periph.i2c_module_enable && !periph.serial_iface_enable |->
      pb_oe[3:0] == (port_b_direction_r[3:0] & ~port_b_data_latch_r[3:0]);
  endproperty
  a_od_gpio: assert property (p_od_gpio) else $error("open drain enable wrong");

  property p_od_zero;
    @(posedge sys_clk) disable iff (!nrst) pb_out[3:0] == 4'h0;
  endproperty
  a_od_zero: assert property (p_od_zero) else $error("open drain level high");

  property p_i2c_sda;
    @(posedge sys_clk) disable iff (!nrst) periph.i2c_module_enable |-> pb_oe[0] == periph.sda_low;
  endproperty
  a_i2c_sda: assert property (p_i2c_sda) else $error("I2C data not routed");

  property p_sci_tx;
    @(posedge sys_clk) disable iff (!nrst) periph.serial_iface_enable |-> pb_oe[2] == !periph.txd_level;
  endproperty
  a_sci_tx: assert property (p_sci_tx) else $error("serial transmit not routed");

  property p_sci_rx;
    @(posedge sys_clk) disable iff (!nrst) periph.serial_iface_enable |-> !pb_oe[3];
  endproperty
  a_sci_rx: assert property (p_sci_rx) else $error("serial receive pin driven");

  property p_tim4;
    @(posedge sys_clk) disable iff (!nrst)
      tim_own[0] |-> pb_oe[4] == periph.tim_oe[0] && pb_out[4] == periph.tim_out[0];
  endproperty
  a_tim4: assert property (p_tim4) else $error("timer pin 4 not routed");

  property p_tim7;
    @(posedge sys_clk) disable iff (!nrst)
      tim_own[3] |-> pb_oe[7] == periph.tim_oe[3] && pb_out[7] == periph.tim_out[3];
  endproperty
  a_tim7: assert property (p_tim7) else $error("timer pin 7 not routed");

  property p_tim_free;
    @(posedge sys_clk) disable iff (!nrst) !tim_own[1] |-> pb_oe[5] == port_b_direction_r[5];
  endproperty
  a_tim_free: assert property (p_tim_free) else $error("released pin lost direction");

  // Port A analog claim
  property p_analog_one;
    @(posedge sys_clk) disable iff (!nrst) $onehot0(pa_analog_en);
  endproperty
  a_analog_one: assert property (p_analog_one) else $error("more than one analog pin");

  property p_led_analog;
    @(posedge sys_clk) disable iff (!nrst) (pa_led_drive & pa_analog_en) == 8'h00;
  endproperty
  a_led_analog: assert property (p_led_analog) else $error("LED drive on analog pin");

  c_write: cover property (@(posedge sys_clk) disable iff (!nrst) wr_go);
  c_read: cover property (@(posedge sys_clk) disable iff (!nrst) wb_ack_o && !wb_we_i);
  c_sci: cover property (@(posedge sys_clk) disable iff (!nrst) periph.serial_iface_enable);
  c_tim: cover property (@(posedge sys_clk) disable iff (!nrst) tim_own != 4'h0);
  c_analog: cover property (@(posedge sys_clk) disable iff (!nrst) pa_analog_en != 8'h00);
endmodule // gpab_top

// ---- gpab_pin_model.sv ----
// Pin model outside both ports: outside drivers; open-drain pins have no pull-up.
// Assumes the block drives each pin as an out/oe pair.
`timescale 1ns/1ps
module gpab_pin_model (
  // Block side
  input wire logic [7:0] pa_out,
  input wire logic [7:0] pa_oe,
  input wire logic [7:0] pb_out,
  input wire logic [7:0] pb_oe,
  // Outside drivers
  input wire logic [7:0] ext_a,
  input wire logic [7:0] ext_b,
  output logic [7:0] pa_pin,
  output logic [7:0] pb_pin
);
  // Driven pins follow the block, others the outside level
  assign pa_pin = (pa_out & pa_oe) | (ext_a & ~pa_oe);
  // Low half can only pull low; the high comes from the outside driver only
  assign pb_pin = {(pb_out[7:4] & pb_oe[7:4]) | (ext_b[7:4] & ~pb_oe[7:4]),
                   ext_b[3:0] & ~pb_oe[3:0]};
endmodule // gpab_pin_model

// ---- tb_top.sv ----
// Self-checking bench for the two-port GPIO block.
// Assumes the register map in gpab_consts.svh and a one-cycle ack.
`timescale 1ns/1ps
`include "gpab_consts.svh"
module tb_top;
  logic sys_clk, nrst, cyc, stb, we, ack;
  logic [7:0] adr, ext_a, ext_b, pa_in, pb_in, pa_out, pa_oe, pa_led, pa_an;
  logic [7:0] pb_out, pb_oe, tels, la, da, lb, db, ld, eo, pbl;
  logic [3:0] eq;
  logic [4:0] asel;
  logic [31:0] dat_w, dat_o, rd;
  gpab_pkg::gpab_periph_t periph;
  int n_errors, tests_run, seed, k, j;
  gpab_top dut (.sys_clk(sys_clk), .nrst(nrst), .clk_en(1'b1), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf), .wb_dat_i(dat_w),
    .wb_dat_o(dat_o), .wb_ack_o(ack), .pa_in(pa_in), .pa_out(pa_out), .pa_oe(pa_oe),
    .pa_led_drive(pa_led), .pa_analog_en(pa_an), .pb_in(pb_in), .pb_out(pb_out),
    .pb_oe(pb_oe), .analog_channel_select(asel), .periph(periph),
    .timer_edge_level_select(tels), .pb_level(pbl));
  gpab_pin_model pins (.pa_out(pa_out), .pa_oe(pa_oe), .pb_out(pb_out), .pb_oe(pb_oe),
    .ext_a(ext_a), .ext_b(ext_b), .pa_pin(pa_in), .pb_pin(pb_in));
  // Free-running 125 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic conclude;
    $display("checks %0d mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    tests_run++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // Classic single cycle; a bounded wait stands in for a hung slave
  task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int i;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat_w <= {24'h000000, d};
    for (i = 0; i < 20 && ack !== 1'b1; i++) @(posedge sys_clk);
    if (i == 20) begin
      chk(32'h0, 32'h1, "ack timeout");
      conclude();
    end
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // Inputs read as pins, outputs as the latch
  function automatic logic [7:0] rdexp(input logic [7:0] l, input logic [7:0] d,
                                       input logic [7:0] p);
    return (l & d) | (p & ~d);
  endfunction
  // Main sequence
  initial begin
    seed = 32'hfc1b1255;
    {cyc, stb, we, adr, dat_w, nrst, ext_a, ext_b, periph, tels} = '0;
    asel = 5'h1f;
    repeat (10) @(posedge sys_clk);
    nrst <= 1'b1;
    wb(0, `GPAB_OFF_PA_DIR, 8'h00); chk(rd, 32'h0, "dir a reset");
    wb(0, `GPAB_OFF_PB_DIR, 8'h00); chk(rd, 32'h0, "dir b reset");
    wb(0, 8'h40, 8'h00); chk(rd, 32'h0, "unmapped read");
    $display("reset test done");
    for (k = 0; k < 16; k++) begin
      {la, da, lb, db} = $random(seed);
      ld = 8'($random(seed));
      ext_a <= 8'($random(seed));
      ext_b <= 8'($random(seed));
      wb(1, `GPAB_OFF_PA_DATA, la);
      wb(1, `GPAB_OFF_PA_DIR, da);
      wb(1, `GPAB_OFF_PA_LED, ld);
      wb(1, `GPAB_OFF_PB_DATA, lb);
      wb(1, `GPAB_OFF_PB_DIR, db);
      wb(0, `GPAB_OFF_PA_DATA, 8'h00); chk(rd, rdexp(la, da, ext_a), "pa read");
      wb(0, `GPAB_OFF_PB_DATA, 8'h00); chk(rd, rdexp(lb, db, ext_b), "pb read");
      wb(0, `GPAB_OFF_PA_DIR, 8'h00); chk(rd, da, "dir a back");
      @(negedge sys_clk);
      chk(pa_oe, da, "pa oe");
      chk(pa_led, ld & da, "led drive");
      chk(pb_oe, {db[7:4], db[3:0] & ~lb[3:0]}, "pb oe");
      chk(pb_out[3:0], 4'h0, "open drain");
      chk(pbl, {(lb[7:4] & db[7:4]) | (ext_b[7:4] & ~db[7:4]), ext_b[3:0] & ~(db[3:0] & ~lb[3:0])}, "pb level");
    end
    $display("data test done");
    wb(1, `GPAB_OFF_PA_DIR, 8'hff);
    for (k = 0; k < 10; k++) begin
      @(posedge sys_clk);
      asel <= k[4:0];
      @(negedge sys_clk);
      chk(pa_an, (k < 8) ? 8'(8'h01 << k) : 8'h00, "analog pin");
      chk(pa_oe, (k < 8) ? 8'(~(8'h01 << k)) : 8'hff, "digital rest");
    end
    asel <= 5'h1f;
    $display("analog test done");
    for (k = 0; k < 12; k++) begin
      @(posedge sys_clk);
      periph <= 13'($random(seed));
      tels <= 8'($random(seed));
      wb(0, `GPAB_OFF_PB_DIR, 8'h00); chk(rd, db, "dir while owned");
      @(negedge sys_clk);
      eo = {db[7:4], db[3:0] & ~lb[3:0]};
      eq = lb[7:4];
      if (periph.i2c_module_enable) eo[1:0] = {periph.scl_low, periph.sda_low};
      if (periph.serial_iface_enable) eo[3:2] = {1'b0, ~periph.txd_level};
      for (j = 0; j < 4; j++) begin
        if (tels[2*j+:2] != 2'h0) begin
          eo[4+j] = periph.tim_oe[j];
          eq[j] = periph.tim_out[j];
        end
      end
      chk(pb_oe, eo, "periph oe");
      chk(pb_out[7:4], eq, "timer out");
    end
    @(posedge sys_clk);
    periph <= '0;
    tels <= 8'h00;
    @(negedge sys_clk);
    chk(pb_oe, {db[7:4], db[3:0] & ~lb[3:0]}, "release");
    $display("peripheral test done");
    wb(1, `GPAB_OFF_PA_DATA, 8'h5a);
    wb(1, `GPAB_OFF_PB_DATA, 8'ha3);
    @(posedge sys_clk);
    nrst <= 1'b0;
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    @(negedge sys_clk);
    chk(pa_out, 8'h5a, "latch a kept");
    chk(pb_out[7:4], 4'ha, "latch b kept");
    chk(pa_oe, 8'h00, "dir a cleared");
    $display("second reset test done");
    conclude();
  end
endmodule // tb_top
